// File: logic/bssp_top.sv
// serial port: SPI and two-wire shift engine with its registers
//
// Overview of operation
// - master or slave, full duplex, both polarities and phases, bit order, select
// - clock driven as master from a chosen source or software level, or held low by two-wire stretch
// - write strobe pulses need polarity 1, timer pulses need polarity 0
// - toggle sources invert the clock on timer or write events
// - a control bit enables slave select; disabled, the input is ignored
// - in spi slave mode, select high stops shifting and counting
// - slave drives data out while select low, releases it while high
// - count interrupt rises when the bit counter reaches eight
// - any data register access clears the count interrupt
// - counter value readable from the serial control register
// - a new transfer before reading drops the interrupt, overwrites the byte
// - power-down bit holds the port off and frees its pins
// - two-wire mode flags every start and stop condition
// - counter advances per bus clock, resets on data access, start, stop
// - two-wire count interrupt after the byte and after the acknowledge
// - count size bit selects eight-bit or one-bit detection
// - bus clock held low on byte interrupt while stretch bit is set
// - two-wire data access clears count interrupt; missed reads lose data
// - writing all ones after a sent byte frees the acknowledge clock
// - received bits latched on the rising bus clock edge
// - msb first, writing top bit zero acknowledges (bit 0 when lsb first); all ones leaves a not-acknowledge
`timescale 1ns/100ps
`include "bssp_consts.svh"
module bssp_top import bssp_pkg::*; (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    input  wire logic       xdata_wr_pulse,
    input  wire logic       timer0_overflow_pulse,
    input  wire logic       timer1_overflow_pulse,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe,
    input  wire logic       din_i,
    output logic            dout_o,
    output logic            dout_oe,
    input  wire logic       ss_n_i,
    output logic            count_interrupt,
    output logic            start_stop_interrupt,
    output logic            pins_gpio
);
    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] pfs;
        logic [3:0] scr;
        logic [1:0] twc;
        logic       pd;
        logic       cnt_irq;
        logic       ss_irq;
        logic       clr;
        logic [3:0] g1;
        logic [3:0] g2;
        logic [3:0] cnt_d;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] ss_s;
        logic       scl_d;
        logic       sda_d;
        logic [7:0] rdata;
    } bssp_top_st_t;

    bssp_top_st_t s_reg;
    bssp_top_st_t s_next;

    logic       en;
    logic       i2c;
    logic       master;
    logic       slave_select_enable;
    logic [3:0] cnt_now;
    logic [3:0] target;
    logic       hit;
    logic       data_acc;
    logic       start_det;
    logic       stop_det;
    logic       stretch;
    logic       lclk;
    logic       cclk;
    logic       link_arst;
    logic       samp_en;
    logic [3:0] lk_cnt;
    logic [3:0] lk_gray;
    logic [7:0] lk_rx;
    logic [2:0] tx_idx;
    logic       tx_bit;
    logic       gen_lvl;
    logic [7:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // decode and events

    assign en     = ~s_reg.pd;
    assign i2c    = s_reg.pfs[`BSSP_PFS_I2C];
    assign master = s_reg.pfs[`BSSP_PFS_MASTER];
    assign slave_select_enable    = s_reg.scr[`BSSP_SCR_ESS];

    assign cnt_now = bssp_from_gray(s_reg.g2);
    // one-bit detection only exists in two-wire mode
    assign target  = (i2c && s_reg.twc[`BSSP_TWC_COUNT_SIZE_SELECT]) ? `BSSP_ONE_BIT
                                                         : `BSSP_BYTE_BITS;
    assign hit     = en && cnt_now == target && s_reg.cnt_d != target;
    assign data_acc = (sfr_wr || sfr_rd) && sfr_addr == `BSSP_ADDR_DATA;

    // start: data falls while clock high; stop: data rises while clock high
    assign start_det = en && i2c && s_reg.scl_s[1] && s_reg.scl_d
                       && s_reg.sda_d && !s_reg.sda_s[1];
    assign stop_det  = en && i2c && s_reg.scl_s[1] && s_reg.scl_d
                       && !s_reg.sda_d && s_reg.sda_s[1];

    assign stretch = en && i2c && s_reg.cnt_irq
                     && cnt_now == `BSSP_BYTE_BITS
                     && s_reg.twc[`BSSP_TWC_STRETCH]
                     && !s_reg.twc[`BSSP_TWC_COUNT_SIZE_SELECT];

    ////////////////////////////////////////////////////////////////////////
    // link side

    // sample edge: rising for modes 0 and 3 and for two-wire, else falling
    assign lclk = sck_i ^ (~i2c & (s_reg.scr[`BSSP_SCR_CPOL]
                                   ^ s_reg.scr[`BSSP_SCR_CPHA]));
    // two-wire counts on the falling bus clock, data still on the rising one
    assign cclk = lclk ^ i2c;
    // counter reset is asynchronous because the bus clock may be stopped
    assign link_arst = rst | s_reg.clr | s_reg.pd;
    assign samp_en = i2c | master | ~slave_select_enable | ~s_reg.ss_s[1];

    bssp_link u_link (
        .lclk      (lclk),
        .cclk      (cclk),
        .arst      (link_arst),
        .sample_en (samp_en),
        .lsb_first (s_reg.scr[`BSSP_SCR_LSB]),
        .din_i     (din_i),
        .cnt_bin   (lk_cnt),
        .cnt_gray  (lk_gray),
        .rx_byte   (lk_rx)
    );

    bssp_clkgen u_clkgen (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .run       (en & master),
        .src       (bssp_src_t'(s_reg.pfs[`BSSP_PFS_SRC_MSB:0])),
        .cpol      (s_reg.scr[`BSSP_SCR_CPOL]),
        .sw_level  (s_reg.pfs[`BSSP_PFS_SW_SCK]),
        .wr_pulse  (xdata_wr_pulse),
        .t0_pulse  (timer0_overflow_pulse),
        .t1_pulse  (timer1_overflow_pulse),
        .sck_lvl   (gen_lvl)
    );

    // outgoing bit comes straight from the data register
    assign tx_idx = s_reg.scr[`BSSP_SCR_LSB] ? lk_cnt[2:0]
                                             : 3'h7 - lk_cnt[2:0];
    assign tx_bit = s_reg.data[tx_idx];

    ////////////////////////////////////////////////////////////////////////
    // pins

    always_comb begin
        sck_o   = 1'b0;
        sck_oe  = 1'b0;
        dout_o  = 1'b0;
        dout_oe = 1'b0;
        if (en && !i2c) begin
            sck_o   = gen_lvl;
            sck_oe  = master;
            dout_o  = tx_bit;
            dout_oe = master | ~slave_select_enable | ~s_reg.ss_s[1];
        end else if (en) begin
            // open drain: only ever pull low
            sck_oe  = (master && !gen_lvl) || stretch;
            dout_oe = ~tx_bit;
        end
    end

    assign pins_gpio            = s_reg.pd;
    assign count_interrupt      = s_reg.cnt_irq;
    assign start_stop_interrupt = s_reg.ss_irq;
    assign sfr_rdata            = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////
    // register read mux

    always_comb begin
        rd_val = 8'h00;
        case (sfr_addr)
            `BSSP_ADDR_SCR:  rd_val = {cnt_now, s_reg.scr};
            `BSSP_ADDR_DATA: rd_val = s_reg.data;
            `BSSP_ADDR_TWC:  rd_val = {4'h0, s_reg.cnt_irq, s_reg.ss_irq,
                                       s_reg.twc};
            `BSSP_ADDR_PDC:  rd_val = {7'h00, s_reg.pd};
            `BSSP_ADDR_PFS:  rd_val = s_reg.pfs;
            default:         rd_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next       = s_reg;
        s_next.g1    = lk_gray;
        s_next.g2    = s_reg.g1;
        s_next.cnt_d = cnt_now;
        s_next.scl_s = {s_reg.scl_s[0], sck_i};
        s_next.sda_s = {s_reg.sda_s[0], din_i};
        s_next.ss_s  = {s_reg.ss_s[0], ss_n_i};
        s_next.scl_d = s_reg.scl_s[1];
        s_next.sda_d = s_reg.sda_s[1];
        s_next.clr   = data_acc | start_det | stop_det;
        if (sfr_rd) begin
            s_next.rdata = rd_val;
        end
        if (hit && cnt_now == `BSSP_BYTE_BITS) begin
            s_next.data = lk_rx;
        end
        if (sfr_wr) begin
            case (sfr_addr)
                `BSSP_ADDR_SCR:  s_next.scr = sfr_wdata[3:0];
                `BSSP_ADDR_DATA: s_next.data = sfr_wdata;
                `BSSP_ADDR_TWC:  s_next.twc = sfr_wdata[1:0];
                `BSSP_ADDR_PDC:  s_next.pd = sfr_wdata[`BSSP_PDC_PD];
                `BSSP_ADDR_PFS:  s_next.pfs = sfr_wdata;
                default: ;
            endcase
        end
        // count flag: cleared by access or by a new transfer, set wins
        if (data_acc || cnt_now != target) begin
            s_next.cnt_irq = 1'b0;
        end
        if (hit) begin
            s_next.cnt_irq = 1'b1;
        end
        if (sfr_wr && sfr_addr == `BSSP_ADDR_TWC
            && sfr_wdata[`BSSP_TWC_SSFLAG]) begin
            s_next.ss_irq = 1'b0;
        end
        if (start_det || stop_det) begin
            s_next.ss_irq = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg      <= '0;
            s_reg.data <= `BSSP_DATA_RST;
            s_reg.pfs  <= `BSSP_PFS_RST;
            s_reg.scr  <= `BSSP_SCR_RST;
            s_reg.twc  <= `BSSP_TWC_RST;
            s_reg.pd   <= `BSSP_PD_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_cnt_irq_set: assert property (
        hit |=> s_reg.cnt_irq)
        else $error("count interrupt missed at target count");
    a_data_clear: assert property (
        data_acc && !hit |=> !s_reg.cnt_irq)
        else $error("data access left count interrupt set");
    a_irq_drop: assert property (
        s_reg.cnt_irq && cnt_now != target |=> !s_reg.cnt_irq)
        else $error("stale count interrupt not dropped");
    a_rx_copy: assert property (
        hit && cnt_now == `BSSP_BYTE_BITS
        && !(sfr_wr && sfr_addr == `BSSP_ADDR_DATA)
        |=> s_reg.data == $past(lk_rx))
        else $error("received byte not moved to data register");
    a_cnt_read: assert property (
        sfr_rd && sfr_addr == `BSSP_ADDR_SCR
        |=> sfr_rdata[7:4] == $past(cnt_now))
        else $error("counter value not readable");
    a_pd_quiet: assert property (
        s_reg.pd |-> !sck_oe && !dout_oe && pins_gpio)
        else $error("pins driven while powered down");
    a_ss_tristate: assert property (
        en && !i2c && !master && slave_select_enable && s_reg.ss_s[1] |-> !dout_oe)
        else $error("slave drove data out with select high");
    a_ss_drive: assert property (
        en && !i2c && !master && !s_reg.ss_s[1] |-> dout_oe)
        else $error("slave released data out with select low");
    a_start_stop: assert property (
        start_det || stop_det |=> s_reg.ss_irq ##1 s_reg.cnt_d == 4'h0
                                  || s_reg.ss_irq)
        else $error("start or stop not flagged");
    a_ctr_reset: assert property (
        data_acc |=> s_reg.clr && lk_cnt == 4'h0)
        else $error("bit counter not reset by data access");
    a_stretch: assert property (
        stretch |-> sck_oe && !sck_o)
        else $error("bus clock not held low during stretch");
    a_ack_drive: assert property (
        en && i2c && sfr_wr && sfr_addr == `BSSP_ADDR_DATA
        && sfr_wdata == 8'h7F && !s_reg.scr[`BSSP_SCR_LSB]
        |=> ##1 dout_oe && !dout_o)
        else $error("acknowledge not driven after write");
    a_nack_release: assert property (
        en && i2c && sfr_wr && sfr_addr == `BSSP_ADDR_DATA
        && sfr_wdata == 8'hFF
        |=> ##1 !dout_oe)
        else $error("not-acknowledge did not release data line");
    a_tw_clear: assert property (
        en && i2c && data_acc && !hit |=> !s_reg.cnt_irq)
        else $error("two-wire data access left count interrupt set");
    a_one_bit: assert property (
        en && i2c && s_reg.twc[`BSSP_TWC_COUNT_SIZE_SELECT] && cnt_now == 4'h1
        && s_reg.cnt_d != 4'h1 |=> s_reg.cnt_irq)
        else $error("one-bit count interrupt missed");
    a_slave_sck: assert property (
        !master |-> !sck_oe || stretch)
        else $error("serial clock driven while not master");
    a_sel_off: assert property (
        en && !i2c && !master && !slave_select_enable |-> dout_oe)
        else $error("select input not ignored while disabled");
    a_pins_back: assert property (
        !s_reg.pd |-> !pins_gpio)
        else $error("pins kept as general I/O while powered up");
    a_stretch_off: assert property (
        !s_reg.twc[`BSSP_TWC_STRETCH] |-> !stretch)
        else $error("bus clock stretched with stretch bit clear");
    a_cond_clear: assert property (
        start_det || stop_det |=> s_reg.clr)
        else $error("start or stop did not clear the bit counter");
endmodule : bssp_top

// File: inc/bssp_consts.svh
// register offsets, field positions, reset values and counts of the serial port
`ifndef BSSP_CONSTS_SVH
`define BSSP_CONSTS_SVH
`define BSSP_ADDR_SCR      8'h9A
`define BSSP_ADDR_DATA     8'h9B
`define BSSP_ADDR_TWC      8'h9D
`define BSSP_ADDR_PDC      8'hF1
`define BSSP_ADDR_PFS      8'hF2
`define BSSP_SCR_CPHA      0
`define BSSP_SCR_CPOL      1
`define BSSP_SCR_LSB       2
`define BSSP_SCR_ESS       3
`define BSSP_PFS_SRC_MSB   2
`define BSSP_PFS_SW_SCK    3
`define BSSP_PFS_I2C       4
`define BSSP_PFS_MASTER    5
`define BSSP_TWC_COUNT_SIZE_SELECT    0
`define BSSP_TWC_STRETCH   1
`define BSSP_TWC_SSFLAG    2
`define BSSP_PDC_PD        0
`define BSSP_DATA_RST      8'h00
`define BSSP_PFS_RST       8'h00
`define BSSP_SCR_RST       4'h0
`define BSSP_TWC_RST       2'h0
`define BSSP_PD_RST        1'b1
`define BSSP_BYTE_BITS     4'h8
`define BSSP_ONE_BIT       4'h1
`endif

// File: inc/bssp_pkg.sv
// types and helper functions of the serial port
package bssp_pkg;
    typedef enum logic [2:0] {
        SRC_SOFT, SRC_WR_PULSE, SRC_WR_TOGGLE, SRC_T0_PULSE,
        SRC_T0_TOGGLE, SRC_T1_PULSE, SRC_T1_TOGGLE, SRC_HOLD
    } bssp_src_t;

    function automatic logic [3:0] bssp_to_gray(input logic [3:0] b);
        return b ^ (b >> 1);
    endfunction : bssp_to_gray

    function automatic logic [3:0] bssp_from_gray(input logic [3:0] g);
        logic [3:0] b;
        b[3] = g[3];
        for (int i = 2; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : bssp_from_gray
endpackage : bssp_pkg

// File: logic/bssp_link.sv
// shift register and bit counter running on the serial clock
`timescale 1ns/100ps
`include "bssp_consts.svh"
module bssp_link import bssp_pkg::*; (
    input  wire logic       lclk,
    input  wire logic       cclk,
    input  wire logic       arst,
    input  wire logic       sample_en,
    input  wire logic       lsb_first,
    input  wire logic       din_i,
    output logic [3:0]      cnt_bin,
    output logic [3:0]      cnt_gray,
    output logic [7:0]      rx_byte
);
    typedef struct packed {
        logic [3:0] cnt;
        logic [3:0] gray;
    } bssp_link_st_t;

    bssp_link_st_t s_reg;
    bssp_link_st_t s_next;
    logic [7:0]    rx_reg;
    logic [7:0]    rx_next;

    always_comb begin
        s_next  = s_reg;
        rx_next = rx_reg;
        if (sample_en) begin
            // a ninth edge starts the next byte and drops the old one
            s_next.cnt = (s_reg.cnt == `BSSP_BYTE_BITS) ? 4'h1
                                                        : s_reg.cnt + 4'h1;
            rx_next    = lsb_first ? {din_i, rx_reg[7:1]}
                                   : {rx_reg[6:0], din_i};
        end
        s_next.gray = bssp_to_gray(s_next.cnt);
    end

    // bits are taken on the sample edge, the count may move on the other
    always_ff @(posedge lclk or posedge arst) begin
        if (arst) begin
            rx_reg <= '0;
        end else begin
            rx_reg <= rx_next;
        end
    end

    always_ff @(posedge cclk or posedge arst) begin
        if (arst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cnt_bin  = s_reg.cnt;
    assign cnt_gray = s_reg.gray;
    assign rx_byte  = rx_reg;

    a_hold_count: assert property (
        @(posedge cclk) disable iff (arst)
        !sample_en |=> s_reg.cnt == $past(s_reg.cnt))
        else $error("bit counter moved while slave select was high");
    a_count_range: assert property (
        @(posedge cclk) disable iff (arst)
        s_reg.cnt <= `BSSP_BYTE_BITS)
        else $error("bit counter ran past eight");
endmodule : bssp_link

// File: logic/bssp_clkgen.sv
// master serial clock from software, write strobe or timer sources
`timescale 1ns/100ps
module bssp_clkgen import bssp_pkg::*; (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  bssp_src_t       src,
    input  wire logic       cpol,
    input  wire logic       sw_level,
    input  wire logic       wr_pulse,
    input  wire logic       t0_pulse,
    input  wire logic       t1_pulse,
    output logic            sck_lvl
);
    typedef struct packed {
        logic lvl;
    } bssp_gen_st_t;

    bssp_gen_st_t s_reg;
    bssp_gen_st_t s_next;

    always_comb begin
        s_next = s_reg;
        if (!run) begin
            s_next.lvl = cpol;
        end else begin
            unique case (src)
                SRC_SOFT:      s_next.lvl = sw_level;
                // pulse sources stay idle when polarity does not suit them
                SRC_WR_PULSE:  s_next.lvl = cpol & ~wr_pulse;
                SRC_T0_PULSE:  s_next.lvl = cpol | t0_pulse;
                SRC_T1_PULSE:  s_next.lvl = cpol | t1_pulse;
                SRC_WR_TOGGLE: s_next.lvl = s_reg.lvl ^ wr_pulse;
                SRC_T0_TOGGLE: s_next.lvl = s_reg.lvl ^ t0_pulse;
                SRC_T1_TOGGLE: s_next.lvl = s_reg.lvl ^ t1_pulse;
                SRC_HOLD:      s_next.lvl = cpol;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sck_lvl = s_reg.lvl;

    a_idle_level: assert property (
        @(posedge ref_clk) disable iff (rst)
        !run |=> sck_lvl == $past(cpol))
        else $error("serial clock not idle while not master");
    a_wr_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        run && src == SRC_WR_PULSE && cpol && wr_pulse |=> !sck_lvl)
        else $error("write strobe gave no clock pulse");
    a_t0_toggle: assert property (
        @(posedge ref_clk) disable iff (rst)
        run && src == SRC_T0_TOGGLE && t0_pulse
        |=> sck_lvl != $past(sck_lvl))
        else $error("timer 0 expiry did not toggle the clock");
endmodule : bssp_clkgen

// File: tb/bssp_peer.sv
// behavioural far-side peer: spi master frames and two-wire bus conditions
`timescale 1ns/100ps
module bssp_peer (
    output logic       sck,
    output logic       ss_n,
    output logic       din,
    input  wire logic  dout,
    input  wire logic  dout_oe
);
    logic [7:0] rx;
    logic [7:0] oe_cnt;

    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        din = 1'b1;
        rx = 8'h00;
        oe_cnt = 8'h00;
    end

    // mode 0 frame, msb first, 160 ns clock, clock still outside frames
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        input logic use_ss);
        rx = 8'h00;
        oe_cnt = 8'h00;
        #37;
        ss_n = ~use_ss;
        #80;
        for (int i = 7; i > 7 - nbits; i--) begin
            din = tx[i];
            #80;
            rx = {rx[6:0], dout};
            oe_cnt = oe_cnt + {7'h00, dout_oe};
            sck = 1'b1;
            #80;
            sck = 1'b0;
        end
        // released line shows the inverse of its last value
        din = ~din;
        #80;
        ss_n = 1'b1;
    endtask : xfer

    // data edge while the clock is high: start for 0, stop for 1
    task automatic bus_cond(input logic lvl);
        din = ~lvl;
        #80;
        sck = 1'b1;
        #80;
        din = lvl;
        #80;
    endtask : bus_cond
endmodule : bssp_peer

// File: tb/bssp_top_tb_top.sv
// self-checking bench of the serial port against its far-side peer
`timescale 1ns/100ps
`include "bssp_consts.svh"
module bssp_top_tb_top;
    logic       ref_clk;
    logic       rst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic       xdata_wr_pulse;
    logic       t0_pulse;
    logic       t1_pulse;
    logic       sck_i;
    logic       sck_o;
    logic       sck_oe;
    logic       din_i;
    logic       dout_o;
    logic       dout_oe;
    logic       count_interrupt;
    logic       start_stop_interrupt;
    logic       pins_gpio;
    logic       p_sck;
    logic       p_ss_n;
    logic       p_din;
    logic       two_wire;
    logic [7:0] rd;
    int         bad_count;
    int         n_checks;

    // open drain bus in two-wire mode, pull-up on both lines
    assign sck_i = sck_oe ? sck_o : p_sck;
    assign din_i = two_wire ? (p_din & ~dout_oe) : p_din;

    bssp_top u_bssp_top (
        .ref_clk               (ref_clk),
        .rst                   (rst),
        .sfr_addr              (sfr_addr),
        .sfr_wdata             (sfr_wdata),
        .sfr_wr                (sfr_wr),
        .sfr_rd                (sfr_rd),
        .sfr_rdata             (sfr_rdata),
        .xdata_wr_pulse        (xdata_wr_pulse),
        .timer0_overflow_pulse (t0_pulse),
        .timer1_overflow_pulse (t1_pulse),
        .sck_i                 (sck_i),
        .sck_o                 (sck_o),
        .sck_oe                (sck_oe),
        .din_i                 (din_i),
        .dout_o                (dout_o),
        .dout_oe               (dout_oe),
        .ss_n_i                (p_ss_n),
        .count_interrupt       (count_interrupt),
        .start_stop_interrupt  (start_stop_interrupt),
        .pins_gpio             (pins_gpio)
    );

    bssp_peer u_bssp_peer (
        .sck     (p_sck),
        .ss_n    (p_ss_n),
        .din     (p_din),
        .dout    (dout_oe ? dout_o : ~dout_o),
        .dout_oe (dout_oe)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : waitc

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        waitc(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        waitc(1);
        sfr_wr = 1'b0;
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] a);
        waitc(1);
        sfr_addr = a;
        sfr_rd = 1'b1;
        waitc(1);
        sfr_rd = 1'b0;
        rd = sfr_rdata;
    endtask : sfr_read

    // one-cycle event: 0 write strobe, 1 timer 0, 2 timer 1
    task automatic pulse(input int which);
        xdata_wr_pulse = (which == 0);
        t0_pulse = (which == 1);
        t1_pulse = (which == 2);
        waitc(1);
        {xdata_wr_pulse, t0_pulse, t1_pulse} = 3'h0;
        waitc(4);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        check_bit(pins_gpio, 1'b1);
        check_bit(sck_oe, 1'b0);
        sfr_read(`BSSP_ADDR_PDC);
        check(rd, 8'h01);
        sfr_read(8'h55);
        check(rd, 8'h00);
    endtask : test_reset

    task automatic test_spi_slave;
        sfr_write(`BSSP_ADDR_PDC, 8'h00);
        sfr_write(`BSSP_ADDR_PFS, 8'h00);
        sfr_write(`BSSP_ADDR_SCR, 8'h08);
        sfr_write(`BSSP_ADDR_DATA, 8'hA5);
        waitc(4);
        check_bit(pins_gpio, 1'b0);
        u_bssp_peer.xfer(8'h3C, 8, 1'b1);
        check(u_bssp_peer.rx, 8'hA5);
        check(u_bssp_peer.oe_cnt, 8'h08);
        check_bit(count_interrupt, 1'b1);
        check_bit(sck_oe, 1'b0);
        sfr_read(`BSSP_ADDR_DATA);
        check(rd, 8'h3C);
        check_bit(count_interrupt, 1'b0);
        waitc(4);
        u_bssp_peer.xfer(8'h00, 8, 1'b1);
        check_bit(count_interrupt, 1'b1);
        u_bssp_peer.xfer(8'hE0, 3, 1'b1);
        check_bit(count_interrupt, 1'b0);
        sfr_read(`BSSP_ADDR_SCR);
        check(rd, 8'h38);
    endtask : test_spi_slave

    task automatic test_ss_gate;
        sfr_write(`BSSP_ADDR_DATA, 8'h5A);
        waitc(4);
        u_bssp_peer.xfer(8'hFF, 8, 1'b0);
        check_bit(count_interrupt, 1'b0);
        check(u_bssp_peer.oe_cnt, 8'h00);
        sfr_read(`BSSP_ADDR_SCR);
        check(rd, 8'h08);
        sfr_write(`BSSP_ADDR_SCR, 8'h00);
        waitc(4);
        u_bssp_peer.xfer(8'h81, 8, 1'b0);
        check_bit(count_interrupt, 1'b1);
        sfr_read(`BSSP_ADDR_DATA);
        check(rd, 8'h81);
    endtask : test_ss_gate

    task automatic test_master_clock;
        logic lvl;
        for (int k = 0; k < 3; k++) begin
            sfr_write(`BSSP_ADDR_PFS, 8'h22 + 8'(2 * k));
            waitc(4);
            check_bit(sck_oe, 1'b1);
            lvl = sck_o;
            pulse(k);
            check_bit(sck_o, ~lvl);
        end
        sfr_write(`BSSP_ADDR_PFS, 8'h28);
        waitc(4);
        check_bit(sck_o, 1'b1);
        sfr_write(`BSSP_ADDR_SCR, 8'h02);
        sfr_write(`BSSP_ADDR_PFS, 8'h21);
        waitc(4);
        check_bit(sck_o, 1'b1);
        pulse(0);
        check_bit(sck_o, 1'b1);
        sfr_write(`BSSP_ADDR_SCR, 8'h00);
        sfr_write(`BSSP_ADDR_PDC, 8'h01);
        waitc(4);
        check_bit(pins_gpio, 1'b1);
        check_bit(sck_oe, 1'b0);
    endtask : test_master_clock

    task automatic test_two_wire;
        sfr_write(`BSSP_ADDR_PDC, 8'h00);
        sfr_write(`BSSP_ADDR_PFS, 8'h10);
        two_wire = 1'b1;
        sfr_write(`BSSP_ADDR_DATA, 8'h7F);
        waitc(3);
        check_bit(dout_oe, 1'b1);
        sfr_write(`BSSP_ADDR_DATA, 8'hFF);
        waitc(3);
        check_bit(dout_oe, 1'b0);
        u_bssp_peer.bus_cond(1'b0);
        waitc(6);
        check_bit(start_stop_interrupt, 1'b1);
        sfr_write(`BSSP_ADDR_TWC, 8'h04);
        waitc(2);
        check_bit(start_stop_interrupt, 1'b0);
        u_bssp_peer.bus_cond(1'b1);
        waitc(6);
        check_bit(start_stop_interrupt, 1'b1);
    endtask : test_two_wire

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        {sfr_wr, sfr_rd, xdata_wr_pulse, t0_pulse, t1_pulse} = 5'h00;
        two_wire = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        waitc(1);
        test_reset();
        test_spi_slave();
        test_ss_gate();
        test_master_clock();
        test_two_wire();
        end_of_test();
    end
endmodule : bssp_top_tb_top
